// ### shared/bcb_pkg.sv
// constants shared by the bridge command bit block
// Overview of operation
// - bus master bit set lets bridge master
// - master bit clear blocks secondary responses
// - special cycle enable reads zero always
// - write and invalidate enable reads zero
// - parity response clear ignores parity errors
// - parity response set flags master parity
// - error report bit gates error messages
// - wait cycle control reads zero always
// - fast back-to-back enable reads zero
// - palette snoop bit reads zero
package bcb_pkg;
  localparam logic [3:0] BCB_REG_CMD = 4'h4;    // command word
  localparam logic [3:0] BCB_REG_STAT = 4'h8;   // status word
  localparam logic [3:0] BCB_REG_IRQ = 4'hC;    // interrupt status
  localparam logic [3:0] BCB_REG_MASK = 4'h0;   // interrupt mask
  localparam int BCB_B_MEM = 1;                 // memory space (not kept)
  localparam int BCB_B_MST = 2;                 // bus master enable
  localparam int BCB_B_SPC = 3;                 // special cycle
  localparam int BCB_B_MWI = 4;                 // write and invalidate
  localparam int BCB_B_PAL = 5;                 // palette snoop
  localparam int BCB_B_PER = 6;                 // parity error response
  localparam int BCB_B_WAIT = 7;                // wait cycle control
  localparam int BCB_B_ERR = 8;                 // error message report enable
  localparam int BCB_B_FB2B = 9;                // fast back-to-back
  localparam int BCB_S_MDPE = 8;                // master data parity error flag
  localparam int BCB_I_MDPE = 0;                // irq bit: parity flag set
  localparam int BCB_I_MSG = 1;                 // irq bit: message sent
  localparam logic [1:0] BCB_IRQ_W = 2'h2;      // irq field width marker
  localparam logic [31:0] BCB_ZERO = 32'h0000_0000;
endpackage

// ### shared/bcb_err_if.sv
// error event bundle between top and error unit
`timescale 1ns/1ps
interface bcb_err_if;
  logic per_en;     // parity response enable
  logic rep_en;     // message report enable
  logic clr_mdpe;   // software clear of parity flag
  logic mdpe;       // parity flag
  logic set_pulse;  // flag set this cycle
  logic msg_pulse;  // message sent this cycle
  modport ctl (output per_en, rep_en, clr_mdpe, input mdpe, set_pulse, msg_pulse);
  modport unit (input per_en, rep_en, clr_mdpe, output mdpe, set_pulse, msg_pulse);
endinterface

// ### rtl/bcb_sync.sv
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
module bcb_sync #(parameter int W = 1) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1; // first stage
    logic [W-1:0] s2; // second stage
  } bcb_sync_t;
  bcb_sync_t st_ff;
  bcb_sync_t nxt_st;
  // shift through two stages
  always_comb begin
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
  end
  // register stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q_o = st_ff.s2;
endmodule

// ### rtl/bcb_err.sv
// parity flag and error message unit
`timescale 1ns/1ps
module bcb_err import bcb_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic parity_err_i,   // synchronised parity error
  input wire logic poison_i,       // poisoned tlp received
  input wire logic fatal_i,        // synchronised fatal event
  input wire logic nonfatal_i,     // synchronised non-fatal event
  output logic msg_fatal_o,        // fatal message request
  output logic msg_nonfatal_o,     // non-fatal message request
  bcb_err_if.unit eif
);
  typedef struct packed {
    logic mdpe;   // sticky parity flag
    logic setp;   // set pulse
    logic mfat;   // fatal message
    logic mnf;    // non-fatal message
  } bcb_err_t;
  bcb_err_t st_ff;
  bcb_err_t nxt_st;
  logic hit;
  // flag and message next state
  always_comb begin
    nxt_st = st_ff;
    hit = parity_err_i | poison_i;
    nxt_st.setp = hit & eif.per_en;
    if (eif.clr_mdpe) begin
      nxt_st.mdpe = 1'b0;
    end
    if (hit && eif.per_en) begin                        // set wins
      nxt_st.mdpe = 1'b1;
    end                                                 // else ignored
    nxt_st.mfat = fatal_i & eif.rep_en;
    nxt_st.mnf = nonfatal_i & eif.rep_en;
  end
  // register state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign eif.mdpe = st_ff.mdpe;
  assign eif.set_pulse = st_ff.setp;
  assign eif.msg_pulse = st_ff.mfat | st_ff.mnf;
  assign msg_fatal_o = st_ff.mfat;
  assign msg_nonfatal_o = st_ff.mnf;

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
      (hit && eif.per_en) |=> eif.mdpe;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("parity flag not set");
  property p_flag_ignore;
    @(posedge clk_i) disable iff (rst_i)
      (!eif.per_en && !eif.mdpe && !eif.clr_mdpe) |=> !eif.mdpe;
  endproperty
  a_flag_ignore: assert property (p_flag_ignore) else $error("flag set while off");
  property p_msg_gate;
    @(posedge clk_i) disable iff (rst_i)
      !$past(eif.rep_en) |-> !(msg_fatal_o || msg_nonfatal_o);
  endproperty
  a_msg_gate: assert property (p_msg_gate) else $error("message while disabled");
  property p_msg_send;
    @(posedge clk_i) disable iff (rst_i)
      (fatal_i && eif.rep_en) |=> msg_fatal_o;
  endproperty
  a_msg_send: assert property (p_msg_send) else $error("fatal message missing");
endmodule

// ### rtl/bcb_top.sv
// command bit bank of the bridge with wishbone slave
`timescale 1ns/1ps
module bcb_top import bcb_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sec_req_i,        // secondary memory or io request pin
  input wire logic parity_err_i,     // parity error pin
  input wire logic poison_i,         // poisoned tlp (core clock)
  input wire logic fatal_i,          // fatal error pin
  input wire logic nonfatal_i,       // non-fatal error pin
  output logic sec_claim_o,          // bridge claims secondary request
  output logic pri_master_o,         // bridge may master primary side
  output logic msg_fatal_o,
  output logic msg_nonfatal_o,
  output logic irq_o
);
  typedef struct packed {
    logic mst;          // bus master enable
    logic per;          // parity error response
    logic rep;          // error message report enable
    logic [1:0] irq;    // sticky interrupt status
    logic [1:0] mask;   // interrupt mask
    logic ack;          // bus answer
    logic [31:0] rdat;  // read data
    logic claim;        // secondary claim
  } bcb_top_t;
  bcb_top_t st_ff;
  bcb_top_t nxt_st;
  logic [3:0] pins_s;     // synchronised pins
  logic req;              // active bus request
  logic wr;               // write strobe this cycle
  logic [31:0] cmd_word;  // assembled command word
  bcb_err_if eif();

  // bring pins into clock domain
  bcb_sync #(.W(4)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({sec_req_i, parity_err_i, fatal_i, nonfatal_i}),
    .q_o(pins_s)
  );

  // parity flag and error messages
  bcb_err u_err (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .parity_err_i(pins_s[2]),
    .poison_i(poison_i),
    .fatal_i(pins_s[1]),
    .nonfatal_i(pins_s[0]),
    .msg_fatal_o(msg_fatal_o),
    .msg_nonfatal_o(msg_nonfatal_o),
    .eif(eif.unit)
  );

  assign req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  assign wr = req & wb_we_i;

  // command word: read-only bits held at zero
  always_comb begin
    cmd_word = BCB_ZERO;
    cmd_word[BCB_B_MST] = st_ff.mst;
    cmd_word[BCB_B_SPC] = 1'b0;
    cmd_word[BCB_B_MWI] = 1'b0;
    cmd_word[BCB_B_PAL] = 1'b0;
    cmd_word[BCB_B_PER] = st_ff.per;
    cmd_word[BCB_B_WAIT] = 1'b0;
    cmd_word[BCB_B_ERR] = st_ff.rep;
    cmd_word[BCB_B_FB2B] = 1'b0;
  end

  // wire control bits to error unit
  assign eif.per_en = st_ff.per;
  assign eif.rep_en = st_ff.rep;
  assign eif.clr_mdpe = wr && (wb_adr_i == BCB_REG_STAT) && wb_sel_i[1]
                        && wb_dat_i[BCB_S_MDPE];

  // bus, control bits and interrupts
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = req;
    nxt_st.rdat = BCB_ZERO;
    // writes: only rw bits stored, others dropped
    if (wr && (wb_adr_i == BCB_REG_CMD)) begin
      if (wb_sel_i[0]) begin
        nxt_st.mst = wb_dat_i[BCB_B_MST];
        nxt_st.per = wb_dat_i[BCB_B_PER];
      end
      if (wb_sel_i[1]) begin
        nxt_st.rep = wb_dat_i[BCB_B_ERR];
      end
    end else if (wr && (wb_adr_i == BCB_REG_IRQ)) begin
      if (wb_sel_i[0]) begin
        nxt_st.irq = st_ff.irq & ~wb_dat_i[1:0];
      end
    end else if (wr && (wb_adr_i == BCB_REG_MASK)) begin
      if (wb_sel_i[0]) begin
        nxt_st.mask = wb_dat_i[1:0];
      end
    end
    // reads
    if (req && !wb_we_i) begin
      if (wb_adr_i == BCB_REG_CMD) begin
        nxt_st.rdat = cmd_word;
      end else if (wb_adr_i == BCB_REG_STAT) begin
        nxt_st.rdat[BCB_S_MDPE] = eif.mdpe;
      end else if (wb_adr_i == BCB_REG_IRQ) begin
        nxt_st.rdat[1:0] = st_ff.irq;
      end else if (wb_adr_i == BCB_REG_MASK) begin
        nxt_st.rdat[1:0] = st_ff.mask;
      end
    end
    // events set sticky bits, set wins over clear
    if (eif.set_pulse) begin
      nxt_st.irq[BCB_I_MDPE] = 1'b1;
    end
    if (eif.msg_pulse) begin
      nxt_st.irq[BCB_I_MSG] = 1'b1;
    end
    // claim secondary only while mastering enabled
    nxt_st.claim = pins_s[3] & st_ff.mst;
  end

  // register state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdat;
  assign sec_claim_o = st_ff.claim;
  assign pri_master_o = st_ff.mst;
  assign irq_o = |(st_ff.irq & st_ff.mask);

  // checks of the bus handshake
  // a taken request
  sequence s_take;
    req;
  endsequence

  // a taken request is answered at the next edge
  property p_ack_follow;
    @(posedge clk_i) disable iff (rst_i)
      s_take |=> wb_ack_o;
  endproperty
  a_ack_follow: assert property (p_ack_follow) else $error("request not answered");

  // no answer without a request one edge before
  property p_ack_cause;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");

  // answer lasts a single cycle
  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  // a taken write
  sequence s_write_any;
    wr;
  endsequence

  // writes answer with zero data
  property p_write_zero;
    @(posedge clk_i) disable iff (rst_i)
      s_write_any |=> wb_dat_o == BCB_ZERO;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("write returned data");

  // checks of the command bits
  // a write of the low command lane
  sequence s_wr_lane0;
    wr && wb_adr_i == BCB_REG_CMD && wb_sel_i[0];
  endsequence

  // a write of the second command lane
  sequence s_wr_lane1;
    wr && wb_adr_i == BCB_REG_CMD && wb_sel_i[1];
  endsequence

  // master bit takes the written value
  property p_mst_wr;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_lane0 |=> pri_master_o == $past(wb_dat_i[BCB_B_MST]);
  endproperty
  a_mst_wr: assert property (p_mst_wr) else $error("master bit not written");

  // master bit moves only on a command write
  property p_mst_keep;
    @(posedge clk_i) disable iff (rst_i)
      !(wr && wb_adr_i == BCB_REG_CMD && wb_sel_i[0]) |=> $stable(pri_master_o);
  endproperty
  a_mst_keep: assert property (p_mst_keep) else $error("master bit moved");

  // parity response bit takes the written value
  property p_per_wr;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_lane0 |=> st_ff.per == $past(wb_dat_i[BCB_B_PER]);
  endproperty
  a_per_wr: assert property (p_per_wr) else $error("parity bit not written");

  // report enable takes the written value
  property p_rep_wr;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_lane1 |=> st_ff.rep == $past(wb_dat_i[BCB_B_ERR]);
  endproperty
  a_rep_wr: assert property (p_rep_wr) else $error("report bit not written");

  // report enable moves only on a command write
  property p_rep_keep;
    @(posedge clk_i) disable iff (rst_i)
      !(wr && wb_adr_i == BCB_REG_CMD && wb_sel_i[1]) |=> $stable(st_ff.rep);
  endproperty
  a_rep_keep: assert property (p_rep_keep) else $error("report bit moved");

  // writable bits are clear on leaving reset
  property p_mst_reset;
    @(posedge clk_i) $fell(rst_i) |-> !pri_master_o && !st_ff.per && !st_ff.rep;
  endproperty
  a_mst_reset: assert property (p_mst_reset) else $error("rw bits not reset");

  // claims only while mastering was on
  property p_no_claim;
    @(posedge clk_i) disable iff (rst_i)
      !$past(st_ff.mst) |-> !sec_claim_o;
  endproperty
  a_no_claim: assert property (p_no_claim) else $error("claim while master off");

  // claim follows a request while mastering is on
  property p_claim_follow;
    @(posedge clk_i) disable iff (rst_i)
      (pins_s[3] && st_ff.mst) |=> sec_claim_o;
  endproperty
  a_claim_follow: assert property (p_claim_follow) else $error("claim missing");

  // a taken read of the command word
  sequence s_read_cmd;
    req && !wb_we_i && wb_adr_i == BCB_REG_CMD;
  endsequence

  // special cycle and write-invalidate bits read zero
  property p_ro_zero;
    @(posedge clk_i) disable iff (rst_i)
      s_read_cmd |=> wb_ack_o && wb_dat_o[BCB_B_SPC] == 1'b0 && wb_dat_o[BCB_B_MWI] == 1'b0;
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("ro bits not zero");

  // wait cycle and fast back-to-back bits read zero
  property p_ro_zero2;
    @(posedge clk_i) disable iff (rst_i)
      s_read_cmd |=> !wb_dat_o[BCB_B_WAIT] && !wb_dat_o[BCB_B_FB2B] && !wb_dat_o[BCB_B_PAL];
  endproperty
  a_ro_zero2: assert property (p_ro_zero2) else $error("unsupported bit nonzero");

  // palette snoop bit reads zero whatever was written
  property p_pal;
    @(posedge clk_i) disable iff (rst_i)
      s_read_cmd |=> !wb_dat_o[BCB_B_PAL];
  endproperty
  a_pal: assert property (p_pal) else $error("palette bit nonzero");

  // bits above nine and the low two bits never read back
  property p_ro_write;
    @(posedge clk_i) disable iff (rst_i)
      s_read_cmd |=> wb_dat_o[31:10] == 22'h0 && wb_dat_o[1:0] == 2'h0;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("dropped bits read back");

  // checks of errors and interrupts
  // non-fatal message goes out while reporting is on
  property p_nf_send;
    @(posedge clk_i) disable iff (rst_i)
      (pins_s[0] && st_ff.rep) |=> msg_nonfatal_o;
  endproperty
  a_nf_send: assert property (p_nf_send) else $error("non-fatal message missing");

  // a taken read of the status word
  sequence s_read_stat;
    req && !wb_we_i && wb_adr_i == BCB_REG_STAT;
  endsequence

  // status read shows the parity flag
  property p_mdpe_read;
    @(posedge clk_i) disable iff (rst_i)
      s_read_stat |=> wb_dat_o[BCB_S_MDPE] == $past(eif.mdpe);
  endproperty
  a_mdpe_read: assert property (p_mdpe_read) else $error("parity flag misread");

  // status read shows nothing but the parity flag
  property p_stat_only;
    @(posedge clk_i) disable iff (rst_i)
      s_read_stat |=> (wb_dat_o & ~(32'h0000_0001 << BCB_S_MDPE)) == BCB_ZERO;
  endproperty
  a_stat_only: assert property (p_stat_only) else $error("stray status bit");

  // parity event sets its sticky interrupt bit
  property p_irq_set;
    @(posedge clk_i) disable iff (rst_i)
      eif.set_pulse |=> st_ff.irq[BCB_I_MDPE];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("parity irq not set");

  // message event sets its sticky interrupt bit
  property p_irq_msg;
    @(posedge clk_i) disable iff (rst_i)
      eif.msg_pulse |=> st_ff.irq[BCB_I_MSG];
  endproperty
  a_irq_msg: assert property (p_irq_msg) else $error("message irq not set");

  // writing one clears the parity interrupt bit when no event
  property p_irq_clear;
    @(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == BCB_REG_IRQ && wb_sel_i[0] && wb_dat_i[BCB_I_MDPE]
        && !eif.set_pulse) |=> !st_ff.irq[BCB_I_MDPE];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq bit not cleared");

  // unmasked pending parity bit drives the interrupt line
  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
      (st_ff.irq[0] && st_ff.mask[0]) |-> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  // a taken read of an address with no register
  sequence s_read_other;
    req && !wb_we_i && wb_adr_i != BCB_REG_CMD && wb_adr_i != BCB_REG_STAT
      && wb_adr_i != BCB_REG_IRQ && wb_adr_i != BCB_REG_MASK;
  endsequence

  // unmapped address reads back zero
  property p_unmapped;
    @(posedge clk_i) disable iff (rst_i)
      s_read_other |=> wb_dat_o == BCB_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// ### tb/bcb_agent.sv
// far-side agent model driving the bridge's event pins
`timescale 1ns/1ps
module bcb_agent #(
  parameter int HOLD = 6  // a fired pin stays high for HOLD+1 cycles
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] fire_i,  // bit0 request, bit1 parity, bit2 fatal, bit3 non-fatal
  output logic [3:0] pins_o
);
  logic [3:0] act_ff;  // pins now asserted
  logic [3:0] cnt_ff;  // cycles left before release
  // hold each fired pin, then release it to its idle low level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_ff <= 4'h0;
      cnt_ff <= 4'h0;
    end else if (fire_i != 4'h0) begin
      act_ff <= fire_i;
      cnt_ff <= 4'(HOLD);
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end else begin
      act_ff <= 4'h0;  // released pins idle low
    end
  end
  assign pins_o = act_ff;
endmodule

// ### tb/bridge_command_bits_test.sv
// self-checking bench for the bridge command bit bank
`timescale 1ns/1ps
module bridge_command_bits_test import bcb_pkg::*;;
  logic clk = 1'b0;  // 50 MHz core clock
  logic rst = 1'b1;  // synchronous reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, poison = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0, fire = 4'h0, pins;
  logic [31:0] dat_w = 32'h0, dat_r, q;
  logic ack, claim, pmst, mf, mnf, irq;
  int n_mismatch = 0;
  int n_compared = 0;
  // clock generation
  always #10 clk = ~clk;
  bcb_agent #(.HOLD(6)) i_bcb_agent (.clk_i(clk), .rst_i(rst), .fire_i(fire), .pins_o(pins));
  bcb_top i_bcb_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .sec_req_i(pins[0]), .parity_err_i(pins[1]), .poison_i(poison), .fatal_i(pins[2]),
    .nonfatal_i(pins[3]), .sec_claim_o(claim), .pri_master_o(pmst), .msg_fatal_o(mf),
    .msg_nonfatal_o(mnf), .irq_o(irq));
  // verdict and end of run
  task results;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic single wishbone cycle, bounded wait for ack
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_r;  // taken at the ack edge
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      results();
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // fire agent pins and stop where the outputs have settled
  task ev(input logic [3:0] f);
    @(posedge clk);
    fire <= f;
    @(posedge clk);
    fire <= 4'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // let released pins drain through the synchronisers
  task quiet;
    repeat (12) @(posedge clk);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(BCB_REG_CMD, 32'h0);
    rd(BCB_REG_STAT, 32'h0);
    rd(BCB_REG_IRQ, 32'h0);
    rd(BCB_REG_MASK, 32'h0);
    #1;
    chk(pmst, 1'b0);
    chk(irq, 1'b0);
    $display("test reset done");
    wr(BCB_REG_CMD, 32'hFFFF_FFFF);
    rd(BCB_REG_CMD, 32'h0000_0144);
    #1;
    chk(pmst, 1'b1);
    ev(4'h1);
    chk(claim, 1'b1);
    quiet();
    wr(BCB_REG_CMD, 32'h0);
    #1;
    chk(pmst, 1'b0);
    ev(4'h1);
    chk(claim, 1'b0);
    rd(BCB_REG_CMD, 32'h0);
    $display("test master done");
    ev(4'h2);
    rd(BCB_REG_STAT, 32'h0);
    quiet();
    wr(BCB_REG_CMD, 32'h0000_0040);
    ev(4'h2);
    rd(BCB_REG_STAT, 32'h0000_0100);
    quiet();
    wr(BCB_REG_STAT, 32'h0000_0100);
    rd(BCB_REG_STAT, 32'h0);
    @(posedge clk);
    poison <= 1'b1;
    @(posedge clk);
    poison <= 1'b0;
    repeat (2) @(posedge clk);
    rd(BCB_REG_STAT, 32'h0000_0100);
    $display("test parity done");
    ev(4'hC);
    chk({mf, mnf}, 2'h0);
    quiet();
    wr(BCB_REG_CMD, 32'h0000_0140);
    ev(4'hC);
    chk({mf, mnf}, 2'h3);
    quiet();
    ev(4'h4);
    chk({mf, mnf}, 2'h2);
    quiet();
    $display("test message done");
    rd(BCB_REG_IRQ, 32'h0000_0003);
    #1;
    chk(irq, 1'b0);
    wr(BCB_REG_MASK, 32'h0000_0003);
    #1;
    chk(irq, 1'b1);
    wr(BCB_REG_IRQ, 32'h0000_0003);
    rd(BCB_REG_IRQ, 32'h0);
    #1;
    chk(irq, 1'b0);
    wr(4'h3, 32'hFFFF_FFFF);
    rd(4'h3, 32'h0);
    rd(BCB_REG_CMD, 32'h0000_0140);
    $display("test irq done");
    results();
  end
endmodule
